// file: rtl/mcc_regs.sv
// Monitor control configuration registers, sequencer and pin control
`timescale 1ns/1ps
//
// Contract
// - Monitoring runs only while enable bit set
// - Routing field picks inputs one/two or diode
// - Input three selection masks load-source bit
// - Interrupt output enabled when bit clear
// - Interrupt polarity: 0 low, 1 high
// - Standby powers down converter and DACs
// - Single mode channel code picks source
// - Code 010 follows routing field
// - Sequencing bit: round robin or single
// - Average sixteen unless averaging disabled
// - Optional 25 ms serial clock timeout
// - Software reset restores all defaults
// - Both registers clear at power-up
// - Load-source bit picks pin or registers
module mcc_regs
  import mcc_pkg::*;
#(
  parameter int SCL_TIMEOUT_CYCLES = MCC_SCL_TIMEOUT_CYCLES
)(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // Register port from the serial engine
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Device pins
  input  wire logic       scl_pin,
  input  wire logic       dac_load_strobe_n,
  output logic            int_pin,
  output logic            int_pin_oe,
  // Neighbouring device logic
  input  wire logic       load_by_register,
  input  wire logic       sw_load_req,
  input  wire logic       int_event,
  input  wire logic       conv_done,
  // Converter and DAC control
  output logic            conv_start,
  output logic      [2:0] conv_source,
  output logic      [4:0] avg_count,
  output logic            adc_power_down,
  output logic            dac_power_down,
  output logic            dac_update,
  output logic            soft_reset,
  output logic            scl_timeout
);

  // Pin synchronisers: bit 0 serial clock, bit 1 load strobe
  // Unpacked so each loop pass owns its own element
  logic       pin_meta_q [2];
  logic       pin_sync_q [2];
  logic       load_prev_q;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_sync
      always_ff @(posedge clk or negedge reset_n)
      begin
        if (!reset_n)
        begin
          pin_meta_q[gi] <= 1'b1;
          pin_sync_q[gi] <= 1'b1;
        end
        else
        begin
          pin_meta_q[gi] <= (gi == 0) ? scl_pin : dac_load_strobe_n;
          pin_sync_q[gi] <= pin_meta_q[gi];
        end
      end
    end
  endgenerate

  // Register file
  logic [7:0] cfg_one_q;
  logic [7:0] cfg_one_d;
  logic [7:0] cfg_two_q;
  logic [7:0] cfg_two_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic       srst_q;
  logic       srst_d;

  always_comb
  begin
    cfg_one_d = cfg_one_q;
    cfg_two_d = cfg_two_q;
    srst_d    = 1'b0;
    rdata_d   = rdata_q;
    // Reserved bit is stored as written and reads back; no decoded field uses it
    if (reg_wr && reg_addr == MCC_ADDR_CFG_ONE)
    begin
      cfg_one_d = reg_wdata;
    end
    if (reg_wr && reg_addr == MCC_ADDR_CFG_TWO)
    begin
      if (reg_wdata[MCC_C2_SW_RESET])
      begin
        // Reset bit is never stored, so it always reads back zero
        cfg_one_d = MCC_CFG_RESET;
        cfg_two_d = MCC_CFG_RESET;
        srst_d    = 1'b1;
      end
      else
      begin
        cfg_two_d = reg_wdata;
      end
    end
    if (reg_rd)
    begin
      case (reg_addr)
        MCC_ADDR_CFG_ONE: rdata_d = cfg_one_q;
        MCC_ADDR_CFG_TWO: rdata_d = cfg_two_q;
        default:          rdata_d = MCC_RDATA_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cfg_one_q <= MCC_CFG_RESET;
      cfg_two_q <= MCC_CFG_RESET;
      rdata_q   <= MCC_RDATA_UNMAPPED;
      srst_q    <= 1'b0;
    end
    else
    begin
      cfg_one_q <= cfg_one_d;
      cfg_two_q <= cfg_two_d;
      rdata_q   <= rdata_d;
      srst_q    <= srst_d;
    end
  end

  // Decoded fields
  logic       mon_en;
  logic       standby;
  logic       single;
  logic       diode;
  logic       analog_input_three_sel;
  logic [2:0] chan;

  assign mon_en   = cfg_one_q[MCC_C1_MON_EN];
  assign standby  = cfg_one_q[MCC_C1_STANDBY];
  assign analog_input_three_sel = cfg_one_q[MCC_C1_ANALOG_INPUT_THREE_SEL];
  assign single   = cfg_two_q[MCC_C2_SINGLE];
  assign chan     = cfg_two_q[MCC_C2_CHAN_HI:MCC_C2_CHAN_LO];
  // Undefined routing codes fall back to inputs one and two
  assign diode    = (cfg_one_q[MCC_C1_ROUTE_HI:MCC_C1_ROUTE_LO] == MCC_ROUTE_DIODE);

  // Single-channel source; reserved codes convert the supply
  function automatic mcc_src_t chan_src(input logic [2:0] code, input logic dio);
    mcc_src_t s;
    case (code)
      MCC_CH_SUPPLY:   s = MCC_SRC_SUPPLY;
      MCC_CH_INT_TEMP: s = MCC_SRC_INT_TEMP;
      MCC_CH_SHARED:   s = dio ? MCC_SRC_EXT_TEMP : MCC_SRC_ANALOG_INPUT_ONE;
      MCC_CH_ANALOG_INPUT_TWO:     s = MCC_SRC_ANALOG_INPUT_TWO;
      MCC_CH_ANALOG_INPUT_THREE:     s = MCC_SRC_ANALOG_INPUT_THREE;
      MCC_CH_ANALOG_INPUT_FOUR:     s = MCC_SRC_ANALOG_INPUT_FOUR;
      default:         s = MCC_SRC_SUPPLY;
    endcase
    return s;
  endfunction

  // Round-robin slot source; stale slots after a reroute stay harmless
  function automatic mcc_src_t slot_src(input logic [2:0] slot, input logic dio,
                                        input logic a3);
    mcc_src_t s;
    case (slot)
      3'h0:    s = MCC_SRC_SUPPLY;
      3'h1:    s = MCC_SRC_INT_TEMP;
      3'h2:    s = dio ? MCC_SRC_EXT_TEMP : MCC_SRC_ANALOG_INPUT_ONE;
      3'h3:    s = dio ? MCC_SRC_EXT_TEMP : MCC_SRC_ANALOG_INPUT_TWO;
      3'h4:    s = a3 ? MCC_SRC_ANALOG_INPUT_THREE : MCC_SRC_ANALOG_INPUT_FOUR;
      default: s = MCC_SRC_ANALOG_INPUT_FOUR;
    endcase
    return s;
  endfunction

  // Next slot skips inputs whose pins serve another function
  function automatic logic [2:0] slot_next(input logic [2:0] slot, input logic dio,
                                           input logic a3);
    logic [2:0] n;
    n = (slot >= MCC_SLOT_LAST) ? MCC_SLOT_FIRST : slot + 3'h1;
    if (n == 3'h3 && dio)
    begin
      n = a3 ? 3'h4 : MCC_SLOT_LAST;
    end
    if (n == 3'h4 && !a3)
    begin
      n = MCC_SLOT_LAST;
    end
    return n;
  endfunction

  // Conversion sequencer
  mcc_seq_t   state_q;
  mcc_seq_t   state_d;
  logic       busy_q;
  logic       busy_d;
  logic [2:0] slot_q;
  logic [2:0] slot_d;
  mcc_src_t   src_q;
  mcc_src_t   src_d;
  logic       start_q;
  logic       start_d;
  logic       pd_q;
  logic       pd_d;
  logic [4:0] avg_q;
  logic [4:0] avg_d;
  logic       run_ok;

  assign run_ok = (state_q == MCC_SEQ_RUN) && mon_en && !standby;

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      MCC_SEQ_IDLE:
        if (standby) state_d = MCC_SEQ_STANDBY;
        else if (mon_en) state_d = MCC_SEQ_RUN;
      MCC_SEQ_RUN:
        if (standby) state_d = MCC_SEQ_STANDBY;
        else if (!mon_en) state_d = MCC_SEQ_IDLE;
      MCC_SEQ_STANDBY:
        if (!standby) state_d = mon_en ? MCC_SEQ_RUN : MCC_SEQ_IDLE;
      default: state_d = MCC_SEQ_IDLE;
    endcase
    start_d = run_ok && !busy_q;
    busy_d  = busy_q;
    slot_d  = slot_q;
    src_d   = src_q;
    if (!run_ok)
    begin
      busy_d = 1'b0;
      slot_d = MCC_SLOT_FIRST;
    end
    else if (start_d)
    begin
      busy_d = 1'b1;
      src_d  = single ? chan_src(chan, diode) : slot_src(slot_q, diode, analog_input_three_sel);
    end
    else if (conv_done)
    begin
      busy_d = 1'b0;
      if (!single)
      begin
        slot_d = slot_next(slot_q, diode, analog_input_three_sel);
      end
    end
    pd_d  = standby;
    avg_d = cfg_two_q[MCC_C2_AVG_DIS] ? MCC_AVG_ONE : MCC_AVG_SIXTEEN;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q <= MCC_SEQ_IDLE;
      busy_q  <= 1'b0;
      slot_q  <= MCC_SLOT_FIRST;
      src_q   <= MCC_SRC_SUPPLY;
      start_q <= 1'b0;
      pd_q    <= 1'b0;
      avg_q   <= MCC_AVG_SIXTEEN;
    end
    else
    begin
      state_q <= state_d;
      busy_q  <= busy_d;
      slot_q  <= slot_d;
      src_q   <= src_d;
      start_q <= start_d;
      pd_q    <= pd_d;
      avg_q   <= avg_d;
    end
  end

  // Interrupt pin and DAC load
  logic int_q;
  logic int_d;
  logic int_oe_q;
  logic int_oe_d;
  logic upd_q;
  logic upd_d;
  logic load_fall;
  logic pin_governs;

  assign load_fall   = load_prev_q && !pin_sync_q[1];
  // Pin is analog while input three is chosen, so it cannot load
  assign pin_governs = !analog_input_three_sel && !load_by_register;

  always_comb
  begin
    int_d    = cfg_one_q[MCC_C1_INT_POL] ? int_event : !int_event;
    int_oe_d = !cfg_one_q[MCC_C1_INT_DIS];
    upd_d    = pin_governs ? load_fall : sw_load_req;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      load_prev_q <= 1'b1;
      int_q       <= 1'b1;
      int_oe_q    <= 1'b0;
      upd_q       <= 1'b0;
    end
    else
    begin
      load_prev_q <= pin_sync_q[1];
      int_q       <= int_d;
      int_oe_q    <= int_oe_d;
      upd_q       <= upd_d;
    end
  end

  mcc_scl_watch #(
    .TIMEOUT_CYCLES (SCL_TIMEOUT_CYCLES)
  ) u_scl_watch (
    .clk     (clk),
    .reset_n (reset_n),
    .enable  (cfg_two_q[MCC_C2_TMO_EN]),
    .scl_low (!pin_sync_q[0]),
    .timeout (scl_timeout)
  );

  assign reg_rdata      = rdata_q;
  assign int_pin        = int_q;
  assign int_pin_oe     = int_oe_q;
  assign conv_start     = start_q;
  assign conv_source    = src_q;
  assign avg_count      = avg_q;
  assign adc_power_down = pd_q;
  assign dac_power_down = pd_q;
  assign dac_update     = upd_q;
  assign soft_reset     = srst_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_mon_off;
    !mon_en |=> !start_q;
  endproperty
  a_mon_off: assert property (p_mon_off) else $error("conversion while stopped");

  property p_rr_diode;
    start_q && $past(!single && diode) |-> src_q != MCC_SRC_ANALOG_INPUT_ONE && src_q != MCC_SRC_ANALOG_INPUT_TWO;
  endproperty
  a_rr_diode: assert property (p_rr_diode) else $error("shared input used in diode mode");

  property p_pin_masked;
    analog_input_three_sel && !sw_load_req |=> !upd_q;
  endproperty
  a_pin_masked: assert property (p_pin_masked) else $error("load pin acted while masked");

  property p_pin_load;
    pin_governs && load_fall |=> upd_q;
  endproperty
  a_pin_load: assert property (p_pin_load) else $error("load pin edge lost");

  property p_int_off;
    cfg_one_q[MCC_C1_INT_DIS] |=> !int_oe_q;
  endproperty
  a_int_off: assert property (p_int_off) else $error("interrupt driven while disabled");

  property p_int_pol;
    1'b1 |=> int_q == ($past(cfg_one_q[MCC_C1_INT_POL]) ? $past(int_event) : !$past(int_event));
  endproperty
  a_int_pol: assert property (p_int_pol) else $error("interrupt polarity wrong");

  property p_standby;
    standby |=> !start_q && pd_q ##1 !start_q;
  endproperty
  a_standby: assert property (p_standby) else $error("converter active in standby");

  property p_single_analog_input_four;
    start_q && $past(single && chan == MCC_CH_ANALOG_INPUT_FOUR) |-> src_q == MCC_SRC_ANALOG_INPUT_FOUR;
  endproperty
  a_single_analog_input_four: assert property (p_single_analog_input_four) else $error("single channel source wrong");

  property p_shared_route;
    start_q && $past(single && chan == MCC_CH_SHARED)
      |-> src_q == ($past(diode) ? MCC_SRC_EXT_TEMP : MCC_SRC_ANALOG_INPUT_ONE);
  endproperty
  a_shared_route: assert property (p_shared_route) else $error("shared code ignores route");

  property p_rr_first;
    start_q && $past(!single && slot_q == MCC_SLOT_FIRST) |-> src_q == MCC_SRC_SUPPLY;
  endproperty
  a_rr_first: assert property (p_rr_first) else $error("round robin start wrong");

  property p_avg;
    1'b1 |=> avg_q == ($past(cfg_two_q[MCC_C2_AVG_DIS]) ? MCC_AVG_ONE : MCC_AVG_SIXTEEN);
  endproperty
  a_avg: assert property (p_avg) else $error("averaging count wrong");

  property p_swreset;
    reg_wr && reg_addr == MCC_ADDR_CFG_TWO && reg_wdata[MCC_C2_SW_RESET]
      |=> srst_q && cfg_one_q == MCC_CFG_RESET && cfg_two_q == MCC_CFG_RESET;
  endproperty
  a_swreset: assert property (p_swreset) else $error("software reset incomplete");

  property p_rsvd_chan;
    start_q && $past(single && chan >= MCC_CH_RSVD_LO) |-> src_q == MCC_SRC_SUPPLY;
  endproperty
  a_rsvd_chan: assert property (p_rsvd_chan) else $error("reserved code mishandled");

  c_rr_run: cover property (start_q && !single ##[1:40] start_q && src_q == MCC_SRC_ANALOG_INPUT_FOUR);
  c_single: cover property (start_q && single);
  c_swreset: cover property (srst_q);
  c_pin_load: cover property (upd_q && pin_governs);

endmodule

// file: rtl/mcc_pkg.sv
// Shared constants and types for the monitor control configuration registers
package mcc_pkg;

  // Register offsets on the internal register port
  localparam logic [7:0] MCC_ADDR_CFG_ONE   = 8'h18;
  localparam logic [7:0] MCC_ADDR_CFG_TWO   = 8'h19;
  localparam logic [7:0] MCC_CFG_RESET      = 8'h00;
  localparam logic [7:0] MCC_RDATA_UNMAPPED = 8'h00;

  // Control register one fields
  localparam int MCC_C1_MON_EN    = 0;
  localparam int MCC_C1_ROUTE_LO  = 1;
  localparam int MCC_C1_ROUTE_HI  = 2;
  localparam int MCC_C1_ANALOG_INPUT_THREE_SEL  = 3;
  localparam int MCC_C1_RESERVED  = 4;
  localparam int MCC_C1_INT_DIS   = 5;
  localparam int MCC_C1_INT_POL   = 6;
  localparam int MCC_C1_STANDBY   = 7;

  // Control register two fields
  localparam int MCC_C2_CHAN_LO   = 0;
  localparam int MCC_C2_CHAN_HI   = 2;
  localparam int MCC_C2_SINGLE    = 4;
  localparam int MCC_C2_AVG_DIS   = 5;
  localparam int MCC_C2_TMO_EN    = 6;
  localparam int MCC_C2_SW_RESET  = 7;

  // Shared pin routing codes
  localparam logic [1:0] MCC_ROUTE_AIN12 = 2'h0;
  localparam logic [1:0] MCC_ROUTE_DIODE = 2'h2;

  // Single-channel select codes
  localparam logic [2:0] MCC_CH_SUPPLY   = 3'h0;
  localparam logic [2:0] MCC_CH_INT_TEMP = 3'h1;
  localparam logic [2:0] MCC_CH_SHARED   = 3'h2;
  localparam logic [2:0] MCC_CH_ANALOG_INPUT_TWO     = 3'h3;
  localparam logic [2:0] MCC_CH_ANALOG_INPUT_THREE     = 3'h4;
  localparam logic [2:0] MCC_CH_ANALOG_INPUT_FOUR     = 3'h5;
  localparam logic [2:0] MCC_CH_RSVD_LO  = 3'h6;

  // Round-robin slots
  localparam logic [2:0] MCC_SLOT_FIRST  = 3'h0;
  localparam logic [2:0] MCC_SLOT_LAST   = 3'h5;

  // Conversion sources as seen by the converter
  typedef enum logic [2:0] {
    MCC_SRC_SUPPLY   = 3'h0,
    MCC_SRC_INT_TEMP = 3'h1,
    MCC_SRC_EXT_TEMP = 3'h2,
    MCC_SRC_ANALOG_INPUT_ONE     = 3'h3,
    MCC_SRC_ANALOG_INPUT_TWO     = 3'h4,
    MCC_SRC_ANALOG_INPUT_THREE     = 3'h5,
    MCC_SRC_ANALOG_INPUT_FOUR     = 3'h6
  } mcc_src_t;

  // Samples per result
  localparam logic [4:0] MCC_AVG_SIXTEEN = 5'h10;
  localparam logic [4:0] MCC_AVG_ONE     = 5'h01;

  // Sequencer states, Gray coded along idle, run, standby
  typedef enum logic [1:0] {
    MCC_SEQ_IDLE    = 2'h0,
    MCC_SEQ_RUN     = 2'h1,
    MCC_SEQ_STANDBY = 2'h3
  } mcc_seq_t;

  // Serial clock low timeout
  localparam int MCC_CLK_HZ         = 20_000_000;
  localparam int MCC_SCL_TIMEOUT_MS = 25;
  localparam int MCC_SCL_TIMEOUT_CYCLES = (MCC_CLK_HZ / 1000) * MCC_SCL_TIMEOUT_MS;

endpackage

// file: rtl/mcc_scl_watch.sv
// Serial clock stuck-low watchdog
`timescale 1ns/1ps
module mcc_scl_watch
  import mcc_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = MCC_SCL_TIMEOUT_CYCLES
)(
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  // Control and observed level
  input  wire logic enable,
  input  wire logic scl_low,
  // Result
  output logic      timeout
);

  localparam int CW = $clog2(TIMEOUT_CYCLES + 1);
  localparam logic [CW-1:0] CNT_LIMIT = CW'(TIMEOUT_CYCLES - 1);
  localparam logic [CW-1:0] CNT_ZERO  = '0;

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic          timeout_q;
  logic          timeout_d;

  // Saturates so one stuck-low episode gives exactly one pulse
  always_comb
  begin
    cnt_d     = cnt_q;
    timeout_d = 1'b0;
    if (!enable || !scl_low)
    begin
      cnt_d = CNT_ZERO;
    end
    else if (cnt_q < CNT_LIMIT)
    begin
      cnt_d = cnt_q + CW'(1);
    end
    else if (cnt_q == CNT_LIMIT)
    begin
      cnt_d     = cnt_q + CW'(1);
      timeout_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt_q     <= '0;
      timeout_q <= 1'b0;
    end
    else
    begin
      cnt_q     <= cnt_d;
      timeout_q <= timeout_d;
    end
  end

  assign timeout = timeout_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_tmo_off;
    !enable |=> !timeout_q;
  endproperty
  a_tmo_off: assert property (p_tmo_off) else $error("timeout fired while disabled");

  property p_tmo_cause;
    timeout_q |-> $past(enable) && $past(scl_low) && ($past(cnt_q) == CNT_LIMIT);
  endproperty
  a_tmo_cause: assert property (p_tmo_cause) else $error("timeout without full low");

  c_tmo: cover property (timeout_q);

endmodule

// file: tb/mcc_host_model.sv
// Host-side model driving the register port
`timescale 1ns/1ps
module mcc_host_model
  import mcc_pkg::*;
(
  // Clock
  input  wire logic       clk,
  // Register port
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata
);
  initial
  begin
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr  = a;
    // Only register one has the reserved bit; register two uses bit 4 for single mode
    reg_wdata = (a == MCC_ADDR_CFG_ONE) ? (d & ~(8'h01 << MCC_C1_RESERVED)) : d;
    reg_wr    = 1'b1;
    @(negedge clk);
    reg_wr    = 1'b0;
    // Released data must not look valid
    reg_wdata = ~reg_wdata;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge clk);
    reg_rd   = 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask
endmodule

// file: tb/test_mcc_regs.sv
// Testbench for the monitor control configuration registers
`timescale 1ns/1ps
module test_mcc_regs
  import mcc_pkg::*;
;
  logic       clk;
  logic       reset_n;
  logic       scl_pin;
  logic       dac_load_strobe_n;
  logic       load_by_register;
  logic       sw_load_req;
  logic       int_event;
  logic       conv_done;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic       int_pin;
  logic       int_pin_oe;
  logic       conv_start;
  logic [2:0] conv_source;
  logic [4:0] avg_count;
  logic       adc_power_down;
  logic       dac_power_down;
  logic       dac_update;
  logic       soft_reset;
  logic       scl_timeout;
  int         fails = 0;
  int         num_checks = 0;
  int         conv_lat = 2;
  int         n_sr = 0;
  int         n_upd = 0;
  int         n_tmo = 0;
  logic [2:0] srcq[$];
  logic [7:0] rv;

  mcc_host_model host_u (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  mcc_regs #(.SCL_TIMEOUT_CYCLES(20)) dut_u (.clk(clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .scl_pin(scl_pin), .dac_load_strobe_n(dac_load_strobe_n),
    .int_pin(int_pin), .int_pin_oe(int_pin_oe), .load_by_register(load_by_register),
    .sw_load_req(sw_load_req), .int_event(int_event), .conv_done(conv_done),
    .conv_start(conv_start), .conv_source(conv_source), .avg_count(avg_count),
    .adc_power_down(adc_power_down), .dac_power_down(dac_power_down),
    .dac_update(dac_update), .soft_reset(soft_reset), .scl_timeout(scl_timeout));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk)
  begin
    if (conv_start === 1'b1)
      srcq.push_back(conv_source);
    if (soft_reset === 1'b1)
      n_sr++;
    if (dac_update === 1'b1)
      n_upd++;
    if (scl_timeout === 1'b1)
      n_tmo++;
  end

  // Converter stand-in: answers each start after conv_lat cycles
  initial
  begin
    conv_done = 1'b0;
    forever
    begin
      @(posedge clk);
      if (conv_start === 1'b1)
      begin
        repeat (conv_lat) @(negedge clk);
        conv_done = 1'b1;
        @(negedge clk);
        conv_done = 1'b0;
      end
    end
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic wait_src(input int n);
    int k;
    k = 0;
    while (srcq.size() < n && k < 400)
    begin
      @(negedge clk);
      k++;
    end
    chk("starts", 8'h01, 8'(srcq.size() >= n));
  endtask

  task automatic t_reset();
    @(negedge clk);
    chk("avg_rst", 8'(MCC_AVG_SIXTEEN), 8'(avg_count));
    chk("pd_rst", 8'h00, 8'({adc_power_down, dac_power_down}));
    chk("oe_rst", 8'h01, 8'(int_pin_oe));
    repeat (20) @(negedge clk);
    chk("idle_starts", 8'h00, 8'(srcq.size()));
    $display("reset done");
  endtask

  task automatic t_regs();
    int s0;
    host_u.wr(8'h1a, 8'hff);
    host_u.rd(8'h1a, rv);
    chk("unmapped", MCC_RDATA_UNMAPPED, rv);
    host_u.rd(MCC_ADDR_CFG_ONE, rv);
    chk("cfg_one_rst", 8'h00, rv);
    host_u.rd(MCC_ADDR_CFG_TWO, rv);
    chk("cfg_two_rst", 8'h00, rv);
    host_u.wr(MCC_ADDR_CFG_ONE, 8'h6e);
    host_u.wr(MCC_ADDR_CFG_TWO, 8'h67);
    host_u.rd(MCC_ADDR_CFG_ONE, rv);
    chk("cfg_one", 8'h6e, rv);
    host_u.rd(MCC_ADDR_CFG_TWO, rv);
    chk("cfg_two", 8'h67, rv);
    chk("avg_off", 8'(MCC_AVG_ONE), 8'(avg_count));
    s0 = n_sr;
    host_u.wr(MCC_ADDR_CFG_TWO, 8'h80);
    repeat (3) @(negedge clk);
    chk("soft_reset", 8'(s0 + 1), 8'(n_sr));
    host_u.rd(MCC_ADDR_CFG_ONE, rv);
    chk("cfg_one_sw", 8'h00, rv);
    host_u.rd(MCC_ADDR_CFG_TWO, rv);
    chk("cfg_two_sw", 8'h00, rv);
    chk("avg_sw", 8'(MCC_AVG_SIXTEEN), 8'(avg_count));
    $display("regs done");
  endtask

  task automatic t_int();
    logic [7:0] cfg;
    for (int i = 0; i < 8; i++)
    begin
      cfg = {1'b0, i[2], i[1], 5'h00};
      host_u.wr(MCC_ADDR_CFG_ONE, cfg);
      int_event = i[0];
      repeat (2) @(negedge clk);
      chk("int_pin_oe", 8'(!cfg[5]), 8'(int_pin_oe));
      chk("int_pin", 8'(cfg[6] ? i[0] : !i[0]), 8'(int_pin));
    end
    int_event = 1'b0;
    $display("interrupt done");
  endtask

  task automatic t_standby();
    host_u.wr(MCC_ADDR_CFG_ONE, 8'h81);
    repeat (3) @(negedge clk);
    chk("pd_on", 8'h03, 8'({adc_power_down, dac_power_down}));
    srcq.delete();
    repeat (30) @(negedge clk);
    chk("standby_starts", 8'h00, 8'(srcq.size()));
    host_u.rd(MCC_ADDR_CFG_ONE, rv);
    chk("cfg_one_pd", 8'h81, rv);
    host_u.wr(MCC_ADDR_CFG_ONE, 8'h00);
    repeat (2) @(negedge clk);
    chk("pd_off", 8'h00, 8'({adc_power_down, dac_power_down}));
    $display("standby done");
  endtask

  task automatic t_robin(input logic [7:0] cfg, input logic [17:0] exp);
    srcq.delete();
    host_u.wr(MCC_ADDR_CFG_ONE, cfg);
    wait_src(6);
    host_u.wr(MCC_ADDR_CFG_ONE, 8'h00);
    for (int i = 0; i < 6; i++)
      chk("robin_src", 8'(exp[17-3*i -: 3]), 8'(srcq[i]));
    repeat (5) @(negedge clk);
    srcq.delete();
    repeat (40) @(negedge clk);
    chk("stopped", 8'h00, 8'(srcq.size()));
    $display("robin %h done", cfg);
  endtask

  task automatic t_single();
    logic [2:0] expv [8];
    logic [2:0] code;
    logic [2:0] ex;
    logic [7:0] c2;
    expv = '{3'h0, 3'h1, 3'h3, 3'h4, 3'h5, 3'h6, 3'h0, 3'h0};
    for (int i = 0; i < 9; i++)
    begin
      code = (i == 8) ? MCC_CH_SHARED : 3'(i);
      ex   = (i == 8) ? 3'h2 : expv[i];
      c2   = {2'b00, i[0], 2'b10, code};
      host_u.wr(MCC_ADDR_CFG_TWO, c2);
      srcq.delete();
      host_u.wr(MCC_ADDR_CFG_ONE, (i == 8) ? 8'h05 : 8'h01);
      wait_src(2);
      host_u.wr(MCC_ADDR_CFG_ONE, 8'h00);
      chk("single_src0", 8'(ex), 8'(srcq[0]));
      chk("single_src1", 8'(ex), 8'(srcq[1]));
      chk("avg", c2[5] ? 8'h01 : 8'h10, 8'(avg_count));
      repeat (12) @(negedge clk);
    end
    host_u.wr(MCC_ADDR_CFG_TWO, 8'h00);
    $display("single done");
  endtask

  task automatic pulse_load(input logic by_pin);
    @(negedge clk);
    if (by_pin)
      dac_load_strobe_n = 1'b0;
    else
      sw_load_req = 1'b1;
    @(negedge clk);
    sw_load_req = 1'b0;
    repeat (3) @(negedge clk);
    dac_load_strobe_n = 1'b1;
    repeat (6) @(negedge clk);
  endtask

  task automatic t_load();
    int u0;
    load_by_register = 1'b1;
    u0 = n_upd;
    pulse_load(1'b1);
    chk("pin_ignored", 8'(u0), 8'(n_upd));
    pulse_load(1'b0);
    chk("upd_sw", 8'(u0 + 1), 8'(n_upd));
    load_by_register = 1'b0;
    pulse_load(1'b0);
    chk("sw_ignored", 8'(u0 + 1), 8'(n_upd));
    pulse_load(1'b1);
    chk("upd_pin", 8'(u0 + 2), 8'(n_upd));
    host_u.wr(MCC_ADDR_CFG_ONE, 8'h08);
    pulse_load(1'b1);
    chk("pin_masked", 8'(u0 + 2), 8'(n_upd));
    pulse_load(1'b0);
    chk("upd_masked", 8'(u0 + 3), 8'(n_upd));
    host_u.wr(MCC_ADDR_CFG_ONE, 8'h00);
    $display("load done");
  endtask

  task automatic scl_low(input int n);
    @(negedge clk);
    scl_pin = 1'b0;
    repeat (n) @(negedge clk);
    scl_pin = 1'b1;
    repeat (4) @(negedge clk);
  endtask

  task automatic t_timeout();
    int t0;
    host_u.wr(MCC_ADDR_CFG_TWO, 8'h40);
    t0 = n_tmo;
    scl_low(10);
    chk("tmo_short", 8'(t0), 8'(n_tmo));
    scl_low(30);
    chk("tmo_long", 8'(t0 + 1), 8'(n_tmo));
    host_u.wr(MCC_ADDR_CFG_TWO, 8'h00);
    scl_low(30);
    chk("tmo_off", 8'(t0 + 1), 8'(n_tmo));
    $display("timeout done");
  endtask

  initial
  begin
    #(20000 * 50);
    fails++;
    conclude();
  end

  initial
  begin
    reset_n = 1'b0;
    scl_pin = 1'b1;
    dac_load_strobe_n = 1'b1;
    load_by_register = 1'b0;
    sw_load_req = 1'b0;
    int_event = 1'b0;
    repeat (16) @(negedge clk);
    reset_n = 1'b1;
    t_reset();
    t_regs();
    t_int();
    t_standby();
    t_robin(8'h01, {3'h0, 3'h1, 3'h3, 3'h4, 3'h6, 3'h0});
    conv_lat = 9;
    t_robin(8'h05, {3'h0, 3'h1, 3'h2, 3'h6, 3'h0, 3'h1});
    t_robin(8'h09, {3'h0, 3'h1, 3'h3, 3'h4, 3'h5, 3'h6});
    conv_lat = 2;
    t_robin(8'h03, {3'h0, 3'h1, 3'h3, 3'h4, 3'h6, 3'h0});
    t_single();
    t_load();
    t_timeout();
    conclude();
  end
endmodule
